// [sfp_pkg.sv]
// Package for the serial frame port of the 14-bit converter
package sfp_pkg;

	// Result word width
	localparam int RESULT_W = 14;
	// Falling serial clock edges needed to finish a conversion
	localparam int CONV_EDGES = 18;
	// Edge count at which the first result bit goes out
	localparam int FIRST_BIT_EDGE = 1;
	// Least acquisition time before a frame opens
	localparam int MIN_ACQUIRE_TIME_NS = 95;
	localparam int REF_CLK_NS = 40;
	// Least time rounds up to whole cycles, never below one
	localparam int MIN_ACQUIRE_CYCLES = ((MIN_ACQUIRE_TIME_NS + REF_CLK_NS - 1) / REF_CLK_NS) < 1 ? 1 :
		((MIN_ACQUIRE_TIME_NS + REF_CLK_NS - 1) / REF_CLK_NS);
	// Width of the trim value
	localparam int TRIM_W = 8;
	// Reset value of the trim
	localparam logic [TRIM_W-1:0] TRIM_RESET = 8'h00;

	// Functional states
	typedef enum logic [1:0] {
		acquire_state,
		convert_state,
		offset_trim_state
	} sfp_state_t;

	// Serial pins as seen by the device
	typedef struct packed {
		logic frame_sel_n;
		logic sclk;
	} sfp_link_in_t;

	// Serial data output with enable (enable active low)
	typedef struct packed {
		logic sdo_o;
		logic sdo_oe_n;
	} sfp_link_out_t;

endpackage : sfp_pkg

// [sfp_sync.sv]
// Two-flop synchroniser for pin inputs
module sfp_sync #(
	parameter int W = 2
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			// Both stages rest at the idle pin level, so no false edge follows reset
			meta_q <= '1;
			dout <= '1;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end

endmodule // sfp_sync

// [sfp_frame_port.sv]
// Serial frame port of a 14-bit successive-approximation converter
// ----------------------------------------------------------------
// How it works
// - One low period of frame select holds one conversion and one result transfer, falling to rising.
// - The data output is released (high impedance) whenever frame select is high.
// - In a frame, serial clock falling edges both step the conversion and shift result bits.
// - The analog input is captured when frame select falls in acquisition, ending it; a frame opened from offset trim keeps the old sample.
// - Acquisition, conversion and offset trim are chosen only from frame select and serial clock, except that reset enters offset trim.
// - After the conversion ends the device goes back to acquisition by itself.
// - Each conversion yields a 14-bit result sent over the data output.
// - Offset trim disconnects the inputs and corrects offset for all later conversions.
// ----------------------------------------------------------------
module sfp_frame_port #(
	parameter int RESULT_W = sfp_pkg::RESULT_W,
	parameter int CONV_EDGES = sfp_pkg::CONV_EDGES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Serial link pins
	input wire sfp_pkg::sfp_link_in_t link_in,
	output sfp_pkg::sfp_link_out_t link_out,
	// Sampled analog value, already digitised by the front end model
	input wire logic [RESULT_W-1:0] analog_in_pos,
	input wire logic [RESULT_W-1:0] analog_in_neg,
	// State and result visibility
	output sfp_pkg::sfp_state_t state,
	output logic [RESULT_W-1:0] result,
	output logic result_valid,
	output logic acquire_short
);

	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	if (RESULT_W < 2 || CONV_EDGES < RESULT_W + sfp_pkg::FIRST_BIT_EDGE) begin : g_bad
		$error("sfp_frame_port: conversion edges cannot carry the result word");
	end

	// ----------------------------------------------------------------
	// Pin sampling and edge detection
	// ----------------------------------------------------------------
	logic [1:0] pins_s;
	logic cs_n_q;
	logic sclk_q;
	logic cs_fall;
	logic cs_rise;
	logic sclk_fall;

	sfp_sync #(.W(2)) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.din({link_in.frame_sel_n, link_in.sclk}),
		.dout(pins_s)
	);

	// Previous sampled levels for edge finding
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cs_n_q <= 1'b1;
			sclk_q <= 1'b1;
		end else begin
			cs_n_q <= pins_s[1];
			sclk_q <= pins_s[0];
		end
	end

	// The link clock must run well below ref_clk/2 or edges are missed
	assign cs_fall = cs_n_q && !pins_s[1];
	assign cs_rise = !cs_n_q && pins_s[1];
	assign sclk_fall = sclk_q && !pins_s[0] && !pins_s[1];

	// ----------------------------------------------------------------
	// Acquisition timer
	// ----------------------------------------------------------------
	localparam int ACQ_W = $clog2(sfp_pkg::MIN_ACQUIRE_CYCLES + 1);
	localparam logic [ACQ_W-1:0] ACQ_DONE = ACQ_W'(sfp_pkg::MIN_ACQUIRE_CYCLES);
	logic [ACQ_W-1:0] acq_cnt_q;

	// Counts the closed-frame time, the part of acquisition the host controls
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			acq_cnt_q <= ACQ_DONE;
		end else if (cs_fall) begin
			acq_cnt_q <= '0;
		end else if (pins_s[1] && acq_cnt_q != ACQ_DONE) begin
			acq_cnt_q <= acq_cnt_q + 1'b1;
		end
	end

	// Flag set anew at each frame opening: this frame opened before acquisition was long enough
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			acquire_short <= 1'b0;
		end else if (cs_fall) begin
			acquire_short <= (acq_cnt_q != ACQ_DONE);
		end
	end

	// ----------------------------------------------------------------
	// State machine
	// ----------------------------------------------------------------
	localparam int EDGE_W = $clog2(CONV_EDGES + 1);
	localparam logic [EDGE_W-1:0] EDGE_LAST = EDGE_W'(CONV_EDGES);
	logic [EDGE_W-1:0] edge_cnt_q;
	logic trim_pending_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= sfp_pkg::offset_trim_state;
		end else begin
			case (state)
				sfp_pkg::acquire_state: begin
					if (cs_fall) begin
						state <= sfp_pkg::convert_state;
					end
				end
				sfp_pkg::convert_state: begin
					// Back to acquire on its own
					if (sclk_fall && edge_cnt_q == EDGE_LAST - 1'b1) begin
						state <= sfp_pkg::acquire_state;
					end else if (cs_rise) begin
						// Frame cut short: result lost, trim next
						state <= sfp_pkg::offset_trim_state;
					end
				end
				sfp_pkg::offset_trim_state: begin
					// Trim ends when a frame opens
					if (cs_fall) begin
						state <= sfp_pkg::convert_state;
					end
				end
				default: begin
					state <= sfp_pkg::acquire_state;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			edge_cnt_q <= '0;
		end else if (cs_fall) begin
			edge_cnt_q <= '0;
		end else if (sclk_fall && edge_cnt_q != EDGE_LAST) begin
			edge_cnt_q <= edge_cnt_q + 1'b1;
		end
	end

	// Delays the trim state one cycle so the trim value is loaded once per trim entry
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			trim_pending_q <= 1'b0;
		end else begin
			trim_pending_q <= (state == sfp_pkg::offset_trim_state);
		end
	end

	// ----------------------------------------------------------------
	// Sampling, trim and result
	// ----------------------------------------------------------------
	logic [RESULT_W-1:0] sample_q;
	logic [sfp_pkg::TRIM_W-1:0] trim_q;
	logic [RESULT_W-1:0] shift_q;
	logic [RESULT_W-1:0] trimmed;
	logic sdo_q;

	// Offset-corrected sample, shared by the shifter and the result word
	assign trimmed = sample_q - RESULT_W'(trim_q);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sample_q <= '0;
		end else if (cs_fall && state != sfp_pkg::offset_trim_state) begin
			sample_q <= analog_in_pos - analog_in_neg;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			trim_q <= sfp_pkg::TRIM_RESET;
		end else if (state == sfp_pkg::offset_trim_state && !trim_pending_q) begin
			// Inputs disconnected: the zero difference is taken as the offset
			trim_q <= sfp_pkg::TRIM_W'(analog_in_neg - analog_in_neg);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			shift_q <= '0;
			result <= '0;
			result_valid <= 1'b0;
		end else begin
			result_valid <= 1'b0;
			if (sclk_fall && state == sfp_pkg::convert_state) begin
				if (edge_cnt_q == EDGE_W'(sfp_pkg::FIRST_BIT_EDGE - 1)) begin
					shift_q <= trimmed;
				end else begin
					shift_q <= {shift_q[RESULT_W-2:0], 1'b0};
				end
				if (edge_cnt_q == EDGE_LAST - 1'b1) begin
					result <= trimmed;
					result_valid <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sdo_q <= 1'b0;
		end else if (pins_s[1]) begin // Parked low so no stale bit shows at turn-on
			sdo_q <= 1'b0;
		end else if (sclk_fall && state == sfp_pkg::convert_state) begin
			if (edge_cnt_q == EDGE_W'(sfp_pkg::FIRST_BIT_EDGE - 1)) begin
				sdo_q <= trimmed[RESULT_W-1];
			end else begin
				sdo_q <= shift_q[RESULT_W-2];
			end
		end
	end

	// ----------------------------------------------------------------
	// Output pin
	// ----------------------------------------------------------------
	// Released while frame select high
	assign link_out.sdo_o = sdo_q;
	assign link_out.sdo_oe_n = pins_s[1];

endmodule // sfp_frame_port

// [sfp_frame_port_assertions.sv]
// Pin-level checks for the serial frame port
module sfp_frame_port_assertions #(
	parameter int RESULT_W = 14,
	parameter int CONV_EDGES = 18
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Pins and status
	input wire sfp_pkg::sfp_link_in_t link_in,
	input wire sfp_pkg::sfp_link_out_t link_out,
	input wire sfp_pkg::sfp_state_t state,
	input wire logic result_valid
);
	// ----------------------------------------
	// Properties, four cycles cover sync delay
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	AST_RELEASED: assert property (link_in.frame_sel_n [*4] |-> link_out.sdo_oe_n)
		else $error("data output driven while frame closed");
	AST_SHIFT_ON_FALL: assert property (
		link_in.sclk [*5] ##0 (!link_out.sdo_oe_n && !$past(link_out.sdo_oe_n)) |-> $stable(link_out.sdo_o))
		else $error("data bit moved without a clock fall");
	AST_CAPTURE: assert property (
		($changed(state) && state == sfp_pkg::convert_state) |-> !link_in.frame_sel_n && !$past(link_in.frame_sel_n, 2))
		else $error("conversion began outside a frame fall");
	AST_IDLE_STATE: assert property (link_in.frame_sel_n [*4] |-> state != sfp_pkg::convert_state)
		else $error("converting with frame closed");
	AST_DONE_PULSE: assert property (
		($past(state) == sfp_pkg::convert_state && state == sfp_pkg::acquire_state) |-> result_valid)
		else $error("no result after conversion ended");
	AST_ONE_CYCLE: assert property (result_valid |=> !result_valid)
		else $error("result pulse longer than one cycle");
	AST_ABORT: assert property (
		(state == sfp_pkg::offset_trim_state && $past(state) == sfp_pkg::convert_state) |-> $past(link_in.frame_sel_n, 2))
		else $error("conversion abandoned inside a frame");
	AST_TRIM_QUIET: assert property (state == sfp_pkg::offset_trim_state |-> !result_valid)
		else $error("result during offset trim");
endmodule // sfp_frame_port_assertions

bind sfp_frame_port sfp_frame_port_assertions #(.RESULT_W(RESULT_W), .CONV_EDGES(CONV_EDGES))
	i_sfp_frame_port_assertions (.ref_clk(ref_clk), .rst(rst), .link_in(link_in),
	.link_out(link_out), .state(state), .result_valid(result_valid));

// [sfp_host_model.sv]
// Host controller model driving frame select and serial clock
module sfp_host_model (
	// Clock
	ref_clk,
	// Serial link
	sdo,
	link_in
);
	timeunit 1ns;
	timeprecision 1ns;
	input wire logic ref_clk;
	input wire logic sdo;
	output sfp_pkg::sfp_link_in_t link_in;
	// Idle: frame closed, serial clock parked high between frames
	initial link_in = 2'b11;
	// ---------------------------------------------------
	// One frame: n clock falls, 320 ns period, then a gap
	// ---------------------------------------------------
	task automatic frame(input int n, input int gap, output logic [13:0] w);
		w = 14'h0;
		link_in.frame_sel_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		// rate scaled down: link edges must be resolvable by ref_clk
		for (int i = 0; i < n; i++) begin
			link_in.sclk <= 1'b0;
			repeat (4) @(posedge ref_clk);
			link_in.sclk <= 1'b1;
			if (i < 14) w = {w[12:0], sdo}; // Sampled at the rise, one ref_clk cycle after the update
			repeat (4) @(posedge ref_clk);
		end
		link_in.frame_sel_n <= 1'b1;
		repeat (gap) @(posedge ref_clk);
	endtask
endmodule // sfp_host_model

// [tb_top.sv]
// Self-checking bench for the serial frame port
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	sfp_pkg::sfp_link_in_t link_in;
	sfp_pkg::sfp_link_out_t link_out;
	logic [13:0] pos = 14'h0;
	logic [13:0] neg = 14'h0;
	sfp_pkg::sfp_state_t state;
	logic [13:0] result;
	logic result_valid;
	logic acquire_short;
	logic sdo_last = 1'b0;
	logic [13:0] exp_q[$];
	int error_cnt = 0;
	int samples_checked = 0;
	int cycles = 0;
	int seed = 4;
	int pg = 6;
	// Released line shows the inverse of its last driven value
	wire logic sdo = link_out.sdo_oe_n ? ~sdo_last : link_out.sdo_o;

	always #20 ref_clk = ~ref_clk;

	sfp_frame_port i_sfp_frame_port (.ref_clk(ref_clk), .rst(rst), .link_in(link_in), .link_out(link_out),
		.analog_in_pos(pos), .analog_in_neg(neg), .state(state), .result(result),
		.result_valid(result_valid), .acquire_short(acquire_short));
	sfp_host_model i_sfp_host_model (.ref_clk(ref_clk), .sdo(sdo), .link_in(link_in));

	// -----------------------
	// Compare and report
	// -----------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] e);
		samples_checked++;
		if (got !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// Result monitor and hang guard
	always @(posedge ref_clk) begin
		if (!link_out.sdo_oe_n) sdo_last <= link_out.sdo_o;
		cycles++;
		if (result_valid === 1'b1) begin
			if (exp_q.size() == 0) chk(16'h1, 16'h0);
			else chk(result, exp_q.pop_front());
		end
		if (cycles == 20000) begin
			error_cnt++;
			conclude();
		end
	end

	// One frame; short frames are aborted and yield nothing
	task automatic run(input int n, input int gap, input logic [13:0] e);
		logic [13:0] got;
		if (n >= 18) exp_q.push_back(e);
		i_sfp_host_model.frame(n, gap, got);
		if (n >= 18) chk(got, e);
		chk(acquire_short, pg < 3);
		chk(state, n < 18 ? sfp_pkg::offset_trim_state : sfp_pkg::acquire_state);
		if (gap > 2) chk(link_out.sdo_oe_n, 1'b1);
		pg = gap;
	endtask

	// Main sequence: trim exit, random frames, short gap, abort, long frame
	initial begin
		logic [13:0] a;
		logic [13:0] b;
		a = 14'($random(seed));
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk(state, sfp_pkg::offset_trim_state);
		pos <= a;
		neg <= a;
		run(18, 6, 14'h0);
		for (int k = 0; k < 7; k++) begin
			if (k != 4) begin
				a = 14'($random(seed));
				b = 14'($random(seed));
			end
			pos <= a;
			neg <= b;
			run(k == 3 ? 10 : k == 5 ? 22 : 18, k == 1 ? 1 : 6, a - b);
		end
		chk(16'(exp_q.size()), 16'h0);
		conclude();
	end
endmodule // tb_top
